// ---- hdl/epc_pkg.sv ----
package epc_pkg;
	// register word indices; byte address is four times the index
	localparam logic [5:0] IDX_ADDR = 6'h01;
	localparam logic [5:0] IDX_DATA = 6'h03;
	localparam logic [5:0] IDX_CTRL = 6'h04;
	localparam logic [5:0] IDX_RELOAD = 6'h05;
	localparam logic [5:0] IDX_COUNT = 6'h06;

	// control register field positions
	localparam int CTRL_RUN_BIT = 7;
	localparam int CTRL_IEN_BIT = 6;
	localparam int CTRL_FLAG_BIT = 5;
	localparam int CTRL_BUSY_BIT = 4;
	localparam int CTRL_MODE_HI = 3;
	localparam int CTRL_MODE_LO = 1;

	// mode select codes (mode_sel_hi, mode_sel_mid, mode_sel_lo)
	localparam logic [2:0] MODE_READ = 3'h0;
	localparam logic [2:0] MODE_INCR = 3'h2;
	localparam logic [1:0] MODE_WRITE_HI = 2'h1;
	localparam logic [2:0] MODE_ERASE_WRITE = 3'h4;
	localparam logic [2:0] MODE_ERASE = 3'h7;

	// reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] LATCH_RST = 8'h00;

	// value of an erased cell, and the last latch index
	localparam logic [7:0] ERASED_BYTE = 8'h00;
	localparam logic [1:0] LAST_LATCH = 2'h3;

	// cycle timer prescaler: one decrement per 480 clock periods
	localparam int PRESCALE_DIV = 480;
	localparam logic [8:0] PRESCALE_LAST = 9'(PRESCALE_DIV - 1);
	localparam logic [8:0] PRESCALE_RST = 9'h000;

	typedef enum {
		EPC_IDLE,
		EPC_WRITE,
		EPC_EW_ERASE,
		EPC_EW_WRITE,
		EPC_ERASE
	} epc_cycle_t;
endpackage

// ---- hdl/epc_nvm_ctrl.sv ----
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - run bit clear halts timer, holds count
// - interrupt request only while enable set
// - underflow sets flag; software sets/clears it
// - writing busy bit starts cycle and timer
// - busy plus mode bits select operation
// - control bit0 and address bit7 read zero
// - address increments after read/write, not erase
// - address counter wraps to zero
// - address bits 6..2 select page
// - bits 1..0 also pick read byte
// - bits 1..0 pick latch; increment stops 3
// - data port read returns array byte directly
// - data port write loads selected latch
// - latches unreadable, OR-loaded, cleared at end
// - latch write sets select flag; cleared end
// - reload preloaded; completion clears busy bit
// - one interval per phase; erase/write two
// - only flagged page bytes are modified
// - write ORs, erase clears, erase/write copies
// - 8-bit timer, /480 prescale, loaded at start
// - erase/write first underflow reloads for write
module epc_nvm_ctrl (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic timer_irq_o
);
	import epc_pkg::*;

	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	logic ack_ff;
	logic [31:0] rdata_ff;
	logic irq_ff;
	logic run_ff;
	logic ien_ff;
	logic flag_ff;
	logic busy_ff;
	logic [2:0] mode_ff;
	logic [6:0] addr_ff;
	logic [7:0] reload_ff;
	logic [7:0] count_ff;
	logic [8:0] prescale_ff;
	epc_cycle_t cycle_ff;
	logic [7:0] latch_ff [4];
	logic [3:0] bsel_ff;
	logic [7:0] nvm_array [128];

	logic req;
	logic wr;
	logic rd;
	logic [5:0] word;
	logic [7:0] wdat;
	logic tick;
	logic underflow;
	logic phase_end;
	logic done;
	logic start;
	logic legal_start;
	logic incr_mode;
	logic data_wr;
	logic data_rd;
	logic [4:0] page_index;
	logic [1:0] byte_or_latch_index;
	logic [7:0] nxt_rdata;

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign timer_irq_o = irq_ff;

	assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign rd = req & ~wb_we_i;
	assign word = wb_adr_i[7:2];
	assign wdat = wb_dat_i[7:0];
	assign page_index = addr_ff[6:2];
	assign byte_or_latch_index = addr_ff[1:0];

	assign data_wr = wr & (word == IDX_DATA);
	assign data_rd = rd & (word == IDX_DATA);
	assign incr_mode = ~busy_ff & (mode_ff == MODE_INCR);

	// only the documented mode codes may launch a page cycle
	always_comb begin
		legal_start = 1'b0;
		if (wdat[CTRL_MODE_HI -: 2] == MODE_WRITE_HI) begin
			legal_start = 1'b1;
		end else if (wdat[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_ERASE_WRITE) begin
			legal_start = 1'b1;
		end else if (wdat[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_ERASE) begin
			legal_start = 1'b1;
		end
	end

	assign start = wr & (word == IDX_CTRL) & wdat[CTRL_BUSY_BIT] &
		~busy_ff & legal_start;

	assign tick = run_ff & (prescale_ff == PRESCALE_LAST);
	assign underflow = tick & (count_ff == COUNT_RST);
	assign phase_end = underflow & (cycle_ff != EPC_IDLE);
	assign done = phase_end & (cycle_ff != EPC_EW_ERASE);

	// bus handshake: one wait state, ack drops the cycle after
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end

	always_comb begin
		case (word)
			IDX_ADDR: nxt_rdata = {1'b0, addr_ff};
			IDX_DATA:
				nxt_rdata = nvm_array[{page_index, byte_or_latch_index}];
			IDX_CTRL: nxt_rdata = {run_ff, ien_ff, flag_ff, busy_ff, mode_ff, 1'b0};
			IDX_RELOAD: nxt_rdata = reload_ff;
			IDX_COUNT: nxt_rdata = count_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata_ff <= 32'h0000_0000;
		end else if (rd) begin
			rdata_ff <= {24'h00_0000, nxt_rdata};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= flag_ff & ien_ff;
		end
	end

	// control register bits
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			run_ff <= 1'b0;
			ien_ff <= 1'b0;
			mode_ff <= MODE_RST;
		end else if (wr && word == IDX_CTRL) begin
			run_ff <= wdat[CTRL_RUN_BIT] | start;
			ien_ff <= wdat[CTRL_IEN_BIT];
			mode_ff <= wdat[CTRL_MODE_HI:CTRL_MODE_LO];
		end
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			flag_ff <= 1'b0;
		end else if (underflow) begin
			flag_ff <= 1'b1;
		end else if (wr && word == IDX_CTRL) begin
			flag_ff <= wdat[CTRL_FLAG_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			busy_ff <= 1'b0;
		end else if (start) begin
			busy_ff <= 1'b1;
		end else if (done) begin
			busy_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cycle_ff <= EPC_IDLE;
		end else if (start) begin
			case (wdat[CTRL_MODE_HI:CTRL_MODE_LO])
				MODE_ERASE_WRITE: cycle_ff <= EPC_EW_ERASE;
				MODE_ERASE: cycle_ff <= EPC_ERASE;
				default: cycle_ff <= EPC_WRITE;
			endcase
		end else if (phase_end) begin
			case (cycle_ff)
				EPC_EW_ERASE: cycle_ff <= EPC_EW_WRITE;
				default: cycle_ff <= EPC_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			reload_ff <= RELOAD_RST;
		end else if (wr && word == IDX_RELOAD) begin
			reload_ff <= wdat;
		end
	end

	// prescaler restarts with each cycle so the first interval is whole
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			prescale_ff <= PRESCALE_RST;
		end else if (start || tick) begin
			prescale_ff <= PRESCALE_RST;
		end else if (run_ff) begin
			prescale_ff <= prescale_ff + 9'h001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			count_ff <= COUNT_RST;
		end else if (start || underflow) begin
			count_ff <= reload_ff;
		end else if (tick) begin
			count_ff <= count_ff - 8'h01;
		end
	end

	// address counter; bit 7 does not exist, so it wraps at 127
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			addr_ff <= ADDR_RST;
		end else if (done && cycle_ff != EPC_ERASE) begin
			addr_ff <= addr_ff + 7'h01;
		end else if (wr && word == IDX_ADDR) begin
			addr_ff <= wdat[6:0];
		end else if (data_rd) begin
			addr_ff <= addr_ff + 7'h01;
		end else if (data_wr && incr_mode &&
			byte_or_latch_index != LAST_LATCH) begin
			addr_ff <= {page_index, byte_or_latch_index + 2'h1};
		end
	end

	// write latches and byte select flags, one lane each
	for (genvar i = 0; i < 4; i++) begin : g_lane
		always_ff @(posedge core_clk) begin
			if (!resetn) begin
				latch_ff[i] <= LATCH_RST;
				bsel_ff[i] <= 1'b0;
			end else if (done) begin
				latch_ff[i] <= LATCH_RST;
				bsel_ff[i] <= 1'b0;
			end else if (data_wr && byte_or_latch_index == 2'(i)) begin
				latch_ff[i] <= latch_ff[i] | wdat;
				bsel_ff[i] <= 1'b1;
			end
		end
	end

	// page update at the end of each phase
	always_ff @(posedge core_clk) begin
		if (phase_end) begin
			for (int b = 0; b < 4; b++) begin
				if (bsel_ff[b]) begin
					case (cycle_ff)
						EPC_ERASE, EPC_EW_ERASE: begin
							nvm_array[{page_index, 2'(b)}] <= ERASED_BYTE;
						end
						EPC_WRITE, EPC_EW_WRITE: begin
							nvm_array[{page_index, 2'(b)}] <=
								nvm_array[{page_index, 2'(b)}] | latch_ff[b];
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	AST_RUN_HALT: assert property (
		!run_ff && !start |=> $stable(count_ff))
		else $error("timer count moved while halted");

	AST_IRQ_GATE: assert property (
		!ien_ff |=> !timer_irq_o)
		else $error("interrupt raised while disabled");

	AST_UNDERFLOW_FLAG: assert property (
		run_ff && prescale_ff == PRESCALE_LAST && count_ff == 8'h00 |=> flag_ff)
		else $error("underflow did not set the timer flag");

	AST_START_BUSY: assert property (
		start |=> busy_ff && run_ff && count_ff == $past(reload_ff))
		else $error("start did not set busy and load timer");

	AST_ZERO_BITS: assert property (
		ack_ff && !wb_we_i && (word == IDX_CTRL || word == IDX_ADDR) |->
		(word == IDX_CTRL ? !rdata_ff[0] : !rdata_ff[7]))
		else $error("reserved bit read as one");

	AST_ERASE_ADDR: assert property (
		done && cycle_ff == EPC_ERASE |=> $stable(addr_ff))
		else $error("address moved after erase");

	AST_READ_INC: assert property (
		data_rd && !done |=> addr_ff == 7'($past(addr_ff) + 7'h01))
		else $error("address did not step after read");

	AST_INC_STOP: assert property (
		data_wr && incr_mode && byte_or_latch_index == LAST_LATCH &&
		!done |=> byte_or_latch_index == LAST_LATCH)
		else $error("latch subcounter passed three");

	AST_END_CLEAR: assert property (
		done |=> !busy_ff && bsel_ff == 4'h0 && flag_ff)
		else $error("cycle end left busy, flags or timer flag wrong");

	AST_EW_PHASE: assert property (
		phase_end && cycle_ff == EPC_EW_ERASE |=>
		busy_ff && cycle_ff == EPC_EW_WRITE && count_ff == $past(reload_ff))
		else $error("erase phase did not reload for write");

	AST_IRQ_FOLLOW: assert property (
		flag_ff && ien_ff |=> timer_irq_o)
		else $error("interrupt missing with flag and enable set");

	AST_DONE_ADDR: assert property (
		done && cycle_ff != EPC_ERASE |=> addr_ff == 7'($past(addr_ff) + 7'h01))
		else $error("address did not step after write cycle");

	AST_LATCH_FLAG: assert property (
		data_wr && !done |=> bsel_ff[$past(byte_or_latch_index)])
		else $error("latch write did not set its select flag");

	AST_ACK_ONE: assert property (
		req |=> ack_ff ##1 !ack_ff)
		else $error("bus ack not a single cycle after request");
endmodule // epc_nvm_ctrl

`default_nettype wire

// ---- test/epc_bus_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// software side of the register bus; the factory test register is never used
module epc_bus_master (
	input wire logic core_clk,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic [31:0] dat_o,
	input wire logic ack
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h00000000;
	end
	// request held until ack is sampled high, then released
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		dat <= {24'h000000, d};
		@(posedge core_clk);
		while (ack !== 1'b1)
			@(posedge core_clk);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
endmodule // epc_bus_master
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import epc_pkg::*;
	localparam logic [7:0] RA = {IDX_ADDR, 2'b00};
	localparam logic [7:0] RD = {IDX_DATA, 2'b00};
	localparam logic [7:0] RC = {IDX_CTRL, 2'b00};
	localparam logic [7:0] PG = 8'h7c;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc, stb, we, ack, irq;
	logic [7:0] adr, v;
	logic [3:0] sel, m;
	logic [31:0] di, dq;
	logic [7:0] la [4];
	logic [7:0] lb [4];
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	int t0;
	initial forever #20 core_clk = ~core_clk;
	epc_nvm_ctrl epc_nvm_ctrl_inst (.core_clk(core_clk), .resetn(resetn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dq), .wb_ack_o(ack),
		.timer_irq_o(irq));
	epc_bus_master epc_bus_master_inst (.core_clk(core_clk), .cyc(cyc),
		.stb(stb), .we(we), .adr(adr), .sel(sel), .dat(di), .dat_o(dq),
		.ack(ack));
	// an erase/write leaves unflagged bytes as they were
	function automatic logic [7:0] merged(input logic f,
		input logic [7:0] fresh, input logic [7:0] old);
		return f ? fresh : old;
	endfunction
	task automatic end_sim;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [7:0] e,
		input logic [7:0] s);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		epc_bus_master_inst.xfer(1'b1, a, d, v);
	endtask
	task automatic chk(input string n, input logic [7:0] a,
		input logic [7:0] e);
		epc_bus_master_inst.xfer(1'b0, a, 8'h00, v);
		cmp(n, e, v);
	endtask
	// start a page cycle, poll until idle, check its length in clocks
	task automatic run(input logic [7:0] c, input int lo, input int hi);
		wr(RC, c);
		t0 = cycles;
		do
			epc_bus_master_inst.xfer(1'b0, RC, 8'h00, v);
		while (v[4] === 1'b1);
		cmp("length", 8'h01, {7'h00, (cycles - t0 >= lo) &&
			(cycles - t0 <= hi)});
		cmp("flag_busy", 8'h02, {6'h00, v[5:4]});
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(32'h784c));
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		chk("ctrl_rst", RC, 8'h00);
		chk("addr_rst", RA, 8'h00);
		chk("count_rst", 8'h18, 8'h00);
		chk("unmapped", 8'h3c, 8'h00);
		wr(RA, 8'hff);
		chk("addr_bit7", RA, 8'h7f);
		wr(RC, 8'h61);
		chk("ctrl_bit0", RC, 8'h60);
		@(posedge core_clk);
		cmp("irq_on", 8'h01, {7'h00, irq});
		wr(RC, 8'h20);
		@(posedge core_clk);
		cmp("irq_off", 8'h00, {7'h00, irq});
		wr(RC, 8'h04);
		wr(RA, PG);
		for (int i = 0; i < 5; i++)
			wr(RD, 8'($urandom));
		chk("incr_stop", RA, 8'h7f);
		run(8'h1e, 470, 490);
		chk("erase_addr", RA, 8'h7f);
		wr(RA, PG);
		for (int i = 0; i < 4; i++)
			chk("erased", RD, ERASED_BYTE);
		chk("wrap", RA, 8'h00);
		for (int i = 0; i < 4; i++)
			la[i] = 8'($urandom);
		wr(RC, 8'h04);
		wr(RA, PG);
		for (int i = 0; i < 4; i++)
			wr(RD, la[i]);
		run(8'h54, 470, 490);
		@(posedge core_clk);
		cmp("irq_done", 8'h01, {7'h00, irq});
		chk("write_addr", RA, 8'h00);
		wr(RA, PG);
		for (int i = 0; i < 4; i++)
			chk("written", RD, la[i]);
		m = 4'($urandom_range(1, 15));
		wr(RC, 8'h00);
		for (int i = 0; i < 4; i++) begin
			lb[i] = 8'($urandom);
			if (m[i]) begin
				wr(RA, 8'(PG + i));
				wr(RD, lb[i]);
			end
		end
		run(8'h18, 950, 970);
		wr(RA, PG);
		for (int i = 0; i < 4; i++)
			chk("masked", RD, merged(m[i], lb[i], la[i]));
		end_sim();
	end
endmodule // testbench
`default_nettype wire
